// *** fbp_pkg.sv ***
/*
  Shared constants and carrier types for the flash block-protection decoder:
  register offsets and field positions, command codes, region sizes, types.
  Assumes a 24-bit flash address space of which the low 20 bits map the array.
*/
`default_nettype none

package fbp_pkg;

  // ------------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------------
  localparam int             ADDR_W        = 24;
  localparam int             ARR_W         = 20;
  localparam int             NUM_LOCKS     = 46;
  localparam int             LOCK_LO_W     = 32;
  localparam int             LOCK_HI_W     = 14;
  localparam int             LOCKS_4K_EACH = 16;
  localparam logic [4:0]     HDR_LAST_BIT  = 5'h1F;
  localparam logic [2:0]     BYTE_LAST_BIT = 3'h7;

  localparam logic [20:0]    ARRAY_SIZE    = 21'h10_0000;
  localparam logic [20:0]    SIZE_32K      = 21'h00_8000;
  localparam logic [20:0]    SIZE_64K      = 21'h01_0000;
  localparam int             UNIT4K_SH     = 12;
  localparam int             UNIT64K_SH    = 16;
  localparam logic [19:0]    TOP_BLOCK_LO  = 20'hF_0000;
  localparam logic [19:0]    ARR_LAST      = 20'hF_FFFF;

  localparam logic [19:0]    PAGE_MASK     = 20'h0_00FF;
  localparam logic [19:0]    BLK4K_MASK    = 20'h0_0FFF;
  localparam logic [19:0]    BLK32K_MASK   = 20'h0_7FFF;
  localparam logic [19:0]    BLK64K_MASK   = 20'h0_FFFF;

  // ------------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------------
  localparam logic [7:0]     OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0]     OPC_ERASE_4K  = 8'h20;
  localparam logic [7:0]     OPC_ERASE_32K = 8'h52;
  localparam logic [7:0]     OPC_ERASE_64K = 8'hD8;

  // ------------------------------------------------------------------
  // register map (byte offsets) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0]     REG_STATUS1   = 8'h00;
  localparam logic [7:0]     REG_STATUS2   = 8'h04;
  localparam logic [7:0]     REG_STATUS3   = 8'h08;
  localparam logic [7:0]     REG_LOCK_LO   = 8'h0C;
  localparam logic [7:0]     REG_LOCK_HI   = 8'h10;
  localparam logic [7:0]     REG_RESULT    = 8'h14;
  localparam logic [7:0]     REG_LAST_ADDR = 8'h18;

  localparam int             SR1_UNIT_BIT  = 6;
  localparam int             SR1_ANCHOR_BIT = 5;
  localparam int             SR1_EXT_LSB   = 2;
  localparam int             SR2_INV_BIT   = 6;
  localparam int             SR3_SCHEME_BIT = 2;
  localparam int             RES_REFUSED_BIT = 0;
  localparam int             RES_SEEN_BIT  = 1;
  localparam int             RES_OPC_LSB   = 8;

  localparam logic [45:0]    LOCK_RESET    = 46'h3FFF_FFFF_FFFF;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OPK_PROG = 2'h0,
    OPK_E4   = 2'h1,
    OPK_E32  = 2'h2,
    OPK_E64  = 2'h3
  } fbp_op_kind_t;

  typedef enum logic [4:0] {
    FS_IDLE  = 5'b00001,
    FS_HDR   = 5'b00010,
    FS_DATA  = 5'b00100,
    FS_ARMED = 5'b01000,
    FS_SKIP  = 5'b10000
  } fbp_fsm_t;

  typedef struct packed {
    logic       region_invert;
    logic       protect_scheme_select;
    logic       protect_unit_size;
    logic       region_anchor_bottom;
    logic [2:0] protect_extent;
  } fbp_prot_cfg_t;

  typedef struct packed {
    fbp_op_kind_t kind;
    logic [23:0]  addr;
  } fbp_erase_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } fbp_prog_t;

endpackage

`default_nettype wire

// *** fbp_spi_host.sv ***
/*
  Serial host model: sends mode-0 command frames, msb first.
  Assumes i_clk is the block's system clock; sck rests low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_spi_host (
  input  wire logic i_clk,
  output var  logic o_sck,
  output var  logic o_cs_n,
  output var  logic o_mosi
);
  // ----------------
  // frame driver
  // ----------------
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // program frames may run past the end of their page, which the decoder wraps; half period is 5 clocks
  task automatic send(input logic [63:0] f, input int n);
    repeat (1 + $urandom % 4) @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_mosi <= f[63-i];
      repeat (5) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // released line shows the inverse so a stale bit is never mistaken for data
    o_mosi <= ~o_mosi;
    repeat (10) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// *** fbp_top.sv ***
/*
  Flash block-protection decoder: samples a mode-0/3 serial command link on
  the system clock, decodes page program and block erase headers, checks the
  target against the range scheme or the per-block lock bits, and issues
  program byte strobes or an erase start. Registers sit on an AHB-Lite slave.
  Assumes the link clock is far slower than i_sys_clk (at least 8 samples a bit).
*/
// Function
// [RULE1] erase blocks hold sixteen 256-byte pages; bits 7:0 address the byte
// [RULE2] page program 02h writes 1..256 bytes confined to one page
// [RULE3] scheme-select bit clear selects range-based protection
// [RULE4] scheme-select bit set uses per-block lock bits instead of range fields
// [RULE5] invert bit set complements the selected region
// [RULE6] unit-size bit picks 64 kB units when clear, 4 kB when set
// [RULE7] anchor bit clear anchors region at top, set anchors at zero
// [RULE8] three-bit extent field at status bits 4:2 sets region extent
// [RULE9] program or erase targeting a protected address is refused
// [RULE10] non-inverted extent zero protects nothing
// [RULE11] 64 kB top: extents 1-4 top 64..512 kB, 5-7 everything
// [RULE12] 64 kB bottom: extents 1-4 bottom 64..512 kB, 5-7 everything
// [RULE13] 4 kB top: extents 1-4 top 4..32 kB, 5 is 32 kB, 6-7 all
// [RULE14] 4 kB bottom: extents 1-4 bottom 4..32 kB, 5 is 32 kB, 6-7 all
// [RULE15] inverted 64 kB top: 0 all, 1-4 all but top part, 5-7 none
// [RULE16] inverted 64 kB bottom: 0 all, 1-4 all but bottom part, 5-7 none
// [RULE17] inverted 4 kB top: 1-4 all but top part, 5 like 4, 6-7 none
// [RULE18] inverted 4 kB bottom: 1-4 all but bottom part, 5 like 4, 6-7 none
// [RULE19] inverted 4 kB top, extents 1-3, 32 kB erase: protect up to 0F7FFF
// [RULE20] inverted 4 kB top, extents 1-5, 64 kB erase: protect up to 0EFFFF
// [RULE21] inverted 4 kB bottom, extents 1-3, 32 kB erase: protect from 008000
// [RULE22] inverted 4 kB bottom, extents 1-5, 64 kB erase: protect from 010000
// [RULE23] erase refused if any byte of its block is protected; array untouched
// [RULE24] decision uses full 24-bit address and current status before starting; the code checks only address bits 19:0
`timescale 1ns/1ps
`default_nettype none

module fbp_top
  import fbp_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output var  logic        o_hreadyout,
  output var  logic [31:0] o_hrdata,
  output var  logic        o_hresp,
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output var  logic        o_erase_start,
  output var  fbp_erase_t  o_erase_op,
  output var  logic        o_prog_strobe,
  output var  fbp_prog_t   o_prog_op,
  output var  logic        o_op_refused
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]    sck_s;
    logic [2:0]    cs_s;
    logic [2:0]    mosi_s;
    logic          sck_v;
    logic          cs_v;
    fbp_fsm_t      fs;
    logic [4:0]    bit_cnt;
    logic [31:0]   shift;
    fbp_op_kind_t  kind;
    logic [23:0]   addr;
    logic [7:0]    page_off;
    logic [2:0]    byte_bit;
    logic [7:0]    byte_sh;
    fbp_prot_cfg_t cfg;
    logic [45:0]   lock;
    logic          res_refused;
    logic          res_seen;
    logic [7:0]    last_opc;
    logic [23:0]   last_addr;
    logic          dp_wr;
    logic [7:0]    dp_addr;
    logic          ready;
    logic [31:0]   hrdata;
    logic          erase_go;
    fbp_erase_t    erase_op;
    logic          prog_go;
    fbp_prog_t     prog_op;
    logic          refused;
  } fbp_state_t;

  fbp_state_t q;
  fbp_state_t nx;
  logic [1:0] rst_ff;
  logic       rst_n;

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic [19:0] op_mask(input fbp_op_kind_t k);
    unique case (k)
      OPK_PROG: op_mask = PAGE_MASK; // [RULE1]
      OPK_E4:   op_mask = BLK4K_MASK;
      OPK_E32:  op_mask = BLK32K_MASK;
      OPK_E64:  op_mask = BLK64K_MASK;
    endcase
  endfunction

  // range scheme: protected interval intersected with the op's block
  function automatic logic range_hit(input fbp_prot_cfg_t c, input fbp_op_kind_t k,
                                     input logic [19:0] lo, input logic [19:0] hi);
    logic [20:0] sz;
    logic        sel_none;
    logic        sel_all;
    logic [20:0] plo;
    logic [20:0] phi;
    logic        pnone;
    sz       = '0;
    sel_none = 1'b0;
    sel_all  = 1'b0;
    unique case (c.protect_extent) // [RULE8]
      3'h0: sel_none = 1'b1; // [RULE10]
      3'h1, 3'h2, 3'h3, 3'h4: begin
        sz = (21'h1 << (c.protect_extent - 3'h1))
             << (c.protect_unit_size ? UNIT4K_SH : UNIT64K_SH); // [RULE6]
      end
      3'h5: begin
        if (c.protect_unit_size) begin
          sz = SIZE_32K; // [RULE13] [RULE14] [RULE17] [RULE18]
        end else begin
          sel_all = 1'b1; // [RULE11] [RULE12]
        end
      end
      default: sel_all = 1'b1;
    endcase
    // inverted fine-unit cases widen for large erases
    if (c.region_invert && c.protect_unit_size && k == OPK_E32 &&
        c.protect_extent >= 3'h1 && c.protect_extent <= 3'h3) begin
      sz = SIZE_32K; // [RULE19] [RULE21]
    end
    if (c.region_invert && c.protect_unit_size && k == OPK_E64 &&
        c.protect_extent >= 3'h1 && c.protect_extent <= 3'h5) begin
      sz = SIZE_64K; // [RULE20] [RULE22]
    end
    pnone = 1'b0;
    plo   = '0;
    phi   = {1'b0, ARR_LAST};
    if (!c.region_invert) begin
      if (sel_none) begin
        pnone = 1'b1;
      end else if (!sel_all) begin
        if (c.region_anchor_bottom) begin // [RULE7]
          phi = sz - 21'h1; // [RULE12] [RULE14]
        end else begin
          plo = ARRAY_SIZE - sz; // [RULE11] [RULE13]
        end
      end
    end else begin // [RULE5]
      if (sel_all) begin
        pnone = 1'b1; // [RULE15] [RULE16] [RULE17] [RULE18]
      end else if (!sel_none) begin
        if (c.region_anchor_bottom) begin
          plo = sz; // [RULE16] [RULE18]
        end else begin
          phi = ARRAY_SIZE - sz - 21'h1; // [RULE15] [RULE17]
        end
      end
    end
    range_hit = !pnone && ({1'b0, lo} <= phi) && ({1'b0, hi} >= plo); // [RULE23]
  endfunction

  // lock scheme: 16 fine locks in each end block, one per middle 64 kB block
  function automatic logic lock_hit(input logic [45:0] lk,
                                    input logic [19:0] lo, input logic [19:0] hi);
    logic [19:0] blo;
    logic [19:0] bhi;
    lock_hit = 1'b0;
    for (int i = 0; i < NUM_LOCKS; i++) begin
      if (i < LOCKS_4K_EACH) begin
        blo = 20'(i) << UNIT4K_SH;
        bhi = blo | BLK4K_MASK;
      end else if (i < 2 * LOCKS_4K_EACH) begin
        blo = TOP_BLOCK_LO | (20'(i - LOCKS_4K_EACH) << UNIT4K_SH);
        bhi = blo | BLK4K_MASK;
      end else begin
        blo = 20'(i - 2 * LOCKS_4K_EACH + 1) << UNIT64K_SH;
        bhi = blo | BLK64K_MASK;
      end
      if (lk[i] && lo <= bhi && hi >= blo) begin
        lock_hit = 1'b1; // [RULE4]
      end
    end
  endfunction

  function automatic logic [31:0] rd_mux(input fbp_state_t s, input logic [7:0] a);
    unique case (a)
      REG_STATUS1: begin
        rd_mux = (32'(s.cfg.protect_unit_size) << SR1_UNIT_BIT)
               | (32'(s.cfg.region_anchor_bottom) << SR1_ANCHOR_BIT)
               | (32'(s.cfg.protect_extent) << SR1_EXT_LSB);
      end
      REG_STATUS2:   rd_mux = 32'(s.cfg.region_invert) << SR2_INV_BIT;
      REG_STATUS3:   rd_mux = 32'(s.cfg.protect_scheme_select) << SR3_SCHEME_BIT;
      REG_LOCK_LO:   rd_mux = s.lock[31:0];
      REG_LOCK_HI:   rd_mux = 32'(s.lock[45:32]);
      REG_RESULT: begin
        rd_mux = (32'(s.res_refused) << RES_REFUSED_BIT)
               | (32'(s.res_seen) << RES_SEEN_BIT)
               | (32'(s.last_opc) << RES_OPC_LSB);
      end
      REG_LAST_ADDR: rd_mux = 32'(s.last_addr);
      default:       rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic         sck_n;
    logic         cs_n;
    logic         mosi_n;
    logic         rise;
    fbp_fsm_t     cur;
    logic [31:0]  w;
    logic         is_op;
    fbp_op_kind_t k;
    logic [19:0]  lo;
    logic [19:0]  hi;
    logic         hit;
    sck_n    = 1'b0;
    cs_n     = 1'b1;
    mosi_n   = 1'b0;
    rise     = 1'b0;
    cur      = FS_IDLE;
    w        = '0;
    is_op    = 1'b0;
    k        = OPK_PROG;
    lo       = '0;
    hi       = '0;
    hit      = 1'b0;
    nx          = q;
    nx.erase_go = 1'b0;
    nx.prog_go  = 1'b0;
    nx.refused  = 1'b0;

    // register writes land in the data phase
    if (q.dp_wr) begin
      unique case (q.dp_addr)
        REG_STATUS1: begin
          nx.cfg.protect_unit_size    = i_hwdata[SR1_UNIT_BIT];
          nx.cfg.region_anchor_bottom = i_hwdata[SR1_ANCHOR_BIT];
          nx.cfg.protect_extent       = i_hwdata[SR1_EXT_LSB +: 3];
        end
        REG_STATUS2: nx.cfg.region_invert = i_hwdata[SR2_INV_BIT];
        REG_STATUS3: nx.cfg.protect_scheme_select = i_hwdata[SR3_SCHEME_BIT];
        REG_LOCK_LO: nx.lock[31:0] = i_hwdata;
        REG_LOCK_HI: nx.lock[45:32] = i_hwdata[LOCK_HI_W-1:0];
        REG_RESULT: begin
          if (i_hwdata[RES_REFUSED_BIT]) begin
            nx.res_refused = 1'b0;
          end
          if (i_hwdata[RES_SEEN_BIT]) begin
            nx.res_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // link pins: three stages, an sck or cs_n change counts once stages 2 and 3 agree; mosi is taken from stage 3
    nx.sck_s  = {q.sck_s[1:0], i_spi_sck};
    nx.cs_s   = {q.cs_s[1:0], i_spi_cs_n};
    nx.mosi_s = {q.mosi_s[1:0], i_spi_mosi};
    sck_n  = (q.sck_s[1] == q.sck_s[2]) ? q.sck_s[2] : q.sck_v;
    cs_n   = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_v;
    mosi_n = q.mosi_s[2];
    nx.sck_v = sck_n;
    nx.cs_v  = cs_n;
    rise     = sck_n & ~q.sck_v;

    if (cs_n) begin
      // erase only starts on a clean frame end with exactly the header
      if (q.fs == FS_ARMED) begin
        nx.erase_go      = 1'b1; // [RULE23]
        nx.erase_op.kind = q.kind;
        nx.erase_op.addr = q.addr;
      end
      nx.fs      = FS_IDLE;
      nx.bit_cnt = '0;
    end else begin
      cur   = (q.fs == FS_IDLE) ? FS_HDR : q.fs;
      nx.fs = cur;
      if (rise) begin
        unique case (cur)
          FS_HDR: begin
            w          = {q.shift[30:0], mosi_n};
            nx.shift   = w;
            nx.bit_cnt = q.bit_cnt + 5'h1;
            if (q.bit_cnt == HDR_LAST_BIT) begin
              is_op = 1'b1;
              unique case (w[31:24])
                OPC_PAGE_PROG: k = OPK_PROG;
                OPC_ERASE_4K:  k = OPK_E4;
                OPC_ERASE_32K: k = OPK_E32;
                OPC_ERASE_64K: k = OPK_E64;
                default:       is_op = 1'b0;
              endcase
              // array is 1 MB; upper address bits alias
              lo  = w[ARR_W-1:0] & ~op_mask(k);
              hi  = w[ARR_W-1:0] | op_mask(k);
              hit = q.cfg.protect_scheme_select ? lock_hit(q.lock, lo, hi)
                                                : range_hit(q.cfg, k, lo, hi); // [RULE3] [RULE24]
              nx.fs = FS_SKIP;
              if (is_op) begin
                nx.kind      = k;
                nx.addr      = w[23:0];
                nx.last_opc  = w[31:24];
                nx.last_addr = w[23:0];
                nx.res_seen  = 1'b1;
                if (hit) begin
                  nx.refused     = 1'b1; // [RULE9]
                  nx.res_refused = 1'b1;
                end else if (k == OPK_PROG) begin
                  nx.fs       = FS_DATA;
                  nx.page_off = w[7:0];
                  nx.byte_bit = '0;
                end else begin
                  nx.fs = FS_ARMED;
                end
              end
            end
          end
          FS_DATA: begin
            nx.byte_sh  = {q.byte_sh[6:0], mosi_n};
            nx.byte_bit = q.byte_bit + 3'h1;
            if (q.byte_bit == BYTE_LAST_BIT) begin
              nx.prog_go      = 1'b1;
              nx.prog_op.addr = {q.addr[23:8], q.page_off}; // [RULE1]
              nx.prog_op.data = {q.byte_sh[6:0], mosi_n};
              // offset wraps, so bytes never leave the page
              nx.page_off     = q.page_off + 8'h01; // [RULE2]
            end
          end
          FS_ARMED: nx.fs = FS_SKIP;
          FS_SKIP:  nx.fs = FS_SKIP;
        endcase
      end
    end

    // address phase; reads see this cycle's writes and flag updates
    nx.dp_wr   = i_hsel & i_htrans[1] & i_hwrite & i_hready;
    nx.dp_addr = i_haddr[7:0];
    if (i_hsel & i_htrans[1] & ~i_hwrite & i_hready) begin
      nx.hrdata = rd_mux(nx, i_haddr[7:0]);
    end
    nx.ready = 1'b1;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.cs_s  <= 3'h7;
      q.cs_v  <= 1'b1;
      q.fs    <= FS_IDLE;
      q.lock  <= LOCK_RESET;
      q.ready <= 1'b1;
    end else begin
      q <= nx;
    end
  end

  assign o_hreadyout   = q.ready;
  assign o_hrdata      = q.hrdata;
  assign o_hresp       = 1'b0;
  assign o_erase_start = q.erase_go;
  assign o_erase_op    = q.erase_op;
  assign o_prog_strobe = q.prog_go;
  assign o_prog_op     = q.prog_op;
  assign o_op_refused  = q.refused;

endmodule

`default_nettype wire

// *** fbp_top_properties.sv ***
/*
  Checker for fbp_top: pulse shapes, program byte order, silence after refusal.
  Assumes it is bound to fbp_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_top_properties
  import fbp_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_arst_n,
  input wire logic       i_spi_cs_n,
  input wire logic       o_erase_start,
  input wire fbp_erase_t o_erase_op,
  input wire logic       o_prog_strobe,
  input wire fbp_prog_t  o_prog_op,
  input wire logic       o_op_refused
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ----------------
  // helper state
  // ----------------
  logic        seen;
  logic        refd;
  logic        cs_q;
  logic [23:0] last;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen <= 1'b0;
      refd <= 1'b0;
      cs_q <= 1'b1;
      last <= 24'h0;
    end else begin
      cs_q <= i_spi_cs_n;
      if (o_prog_strobe) begin
        seen <= 1'b1;
        last <= o_prog_op.addr;
      end else if (i_spi_cs_n) begin
        seen <= 1'b0;
      end
      // refusal stays remembered until the next frame opens
      if (o_op_refused) begin
        refd <= 1'b1;
      end else if (cs_q && !i_spi_cs_n) begin
        refd <= 1'b0;
      end
    end
  end

  // ----------------
  // properties
  // ----------------
  start_pulse_a: assert property (o_erase_start |=> !o_erase_start)
    else $error("erase start wider than one cycle");
  refuse_pulse_a: assert property (o_op_refused |=> !o_op_refused)
    else $error("refusal wider than one cycle");
  strobe_gap_a: assert property (o_prog_strobe |=> !o_prog_strobe [*8])
    else $error("program strobes too close");
  start_kind_a: assert property (o_erase_start |-> o_erase_op.kind != OPK_PROG)
    else $error("erase start with program kind");
  start_after_cs_a: assert property (o_erase_start |->
    i_spi_cs_n && $past(i_spi_cs_n, 2))
    else $error("erase started before frame end");
  strobe_in_frame_a: assert property (o_prog_strobe |-> !$past(i_spi_cs_n, 2))
    else $error("program strobe outside a frame");
  page_wrap_a: assert property (o_prog_strobe && seen |->
    o_prog_op.addr == {last[23:8], last[7:0] + 8'h01})
    else $error("program byte left its page");
  refused_quiet_a: assert property ((o_prog_strobe || o_erase_start) |->
    !refd)
    else $error("work started after refusal");
  erase_hold_a: assert property ($changed(o_erase_op) |-> o_erase_start)
    else $error("erase op changed without start");
  prog_hold_a: assert property ($changed(o_prog_op) |-> o_prog_strobe)
    else $error("program op changed without strobe");

  cover property (o_erase_start);
  cover property (o_op_refused);
  cover property (o_prog_strobe && seen);
endmodule

`default_nettype wire

// *** testbench.sv ***
/*
  Testbench for fbp_top: AHB-Lite register tasks, frames through the host
  model, protection outcomes from a bench function.
  Assumes fbp_pkg, fbp_top, the host model and the checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import fbp_pkg::*;
;
  localparam int          ARR = 32'h0010_0000;
  localparam logic [7:0]  OPC [4] = '{OPC_PAGE_PROG, OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K};
  localparam logic [23:0] EDG [8] = '{24'h00_0000, 24'h00_F000, 24'h01_0000, 24'h0F_0000,
                                      24'h0F_F000, 24'h0F_8000, 24'h00_7000, 24'h0E_F000};
  logic        clk, arst_n, hsel, hwrite, hrdy, hresp, sck, cs_n, mosi, es, ps, rf;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [23:0] a;
  fbp_erase_t  eop, last_e;
  fbp_prog_t   pop;
  fbp_prog_t   pq[$];
  int          n_errors, checks, ns, nr;

  fbp_top u_fbp_top (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp), .i_spi_sck(sck),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_erase_start(es), .o_erase_op(eop),
    .o_prog_strobe(ps), .o_prog_op(pop), .o_op_refused(rf)
  );
  fbp_spi_host u_fbp_spi_host (.i_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // sampled mid-cycle so registered pulses have settled
  always @(negedge clk) begin
    if (es === 1'b1) begin
      ns++;
      last_e = eop;
    end
    if (rf === 1'b1) begin
      nr++;
    end
    if (ps === 1'b1) begin
      pq.push_back(pop);
    end
  end

  // ----------------
  // tasks
  // ----------------
  task automatic chk(input bit ok);
    checks++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH %0t compare %0d failed", $time, checks);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] ex);
    ahb(1'b0, ad, 32'h0);
    chk(rd === ex && hresp === 1'b0);
  endtask

  task automatic frm(input logic [63:0] f, input int n, input int e_r, e_s, e_p);
    int r0;
    int s0;
    r0 = nr;
    s0 = ns;
    pq.delete();
    u_fbp_spi_host.send(f, n);
    repeat (16) @(posedge clk);
    chk(nr - r0 == e_r && ns - s0 == e_s && pq.size() == e_p);
  endtask

  function automatic bit exp_ref(input logic [5:0] c, input int k, input int ad);
    int m, lo, hi, len, b, x;
    x = c[2:0];
    m = (k == 0) ? 32'hFF : (k == 1) ? 32'hFFF : (k == 2) ? 32'h7FFF : 32'hFFFF;
    b = ad & (ARR - 1) & ~m;
    if (x == 0) len = 0;
    else if (x > (c[4] ? 5 : 4)) len = ARR;
    else len = (c[4] ? 32'h1000 : 32'h1_0000) << ((x > 4) ? 3 : x - 1);
    lo = c[3] ? 0 : ARR - len;
    hi = c[3] ? len - 1 : ARR - 1;
    if (c[5]) begin
      lo = c[3] ? len : 0;
      hi = c[3] ? ARR - 1 : ARR - 1 - len;
      if (c[4] && x != 0 && ((k == 2 && x <= 3) || (k == 3 && x <= 5))) begin
        lo = c[3] ? m + 1 : 0;
        hi = c[3] ? ARR - 1 : ARR - 2 - m;
      end
    end
    return b <= hi && b + m >= lo;
  endfunction

  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #600_000;
    n_errors++;
    give_verdict();
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    bit         ex;
    logic [5:0] c;
    int         k;
    k = $urandom(32'h4885);
    arst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rchk(8'h1C, 32'h0);
    rchk(REG_STATUS1, 32'h0);
    rchk(REG_STATUS2, 32'h0);
    rchk(REG_STATUS3, 32'h0);
    rchk(REG_LOCK_LO, 32'hFFFF_FFFF);
    rchk(REG_LOCK_HI, 32'h0000_3FFF);
    for (int i = 0; i < 128; i++) begin
      c = 6'(i >> 1);
      if (i[0] == 1'b0) begin
        ahb(1'b1, REG_STATUS1, {25'h0, c[4:0], 2'h0});
        ahb(1'b1, REG_STATUS2, {25'h0, c[5], 6'h0});
        rchk(REG_STATUS1, {25'h0, c[4:0], 2'h0});
      end
      k = $urandom_range(3, 1);
      a = i[0] ? 24'($urandom) : EDG[$urandom % 8];
      ex = exp_ref(c, k, int'(a));
      frm({OPC[k], a, 32'h0}, 32, ex, !ex, 0);
      if (!ex) begin
        chk(last_e === {fbp_op_kind_t'(k), a});
      end
    end
    ahb(1'b1, REG_STATUS1, 32'h0);
    ahb(1'b1, REG_STATUS2, 32'h0);
    a = {4'h0, 12'($urandom), 8'hFD};
    d = $urandom;
    frm({OPC_PAGE_PROG, a, d}, 64, 0, 0, 4);
    for (int j = 0; j < 4; j++) begin
      chk(pq[j] === {a[23:8], 8'(a[7:0] + j), d[31-8*j -: 8]});
    end
    ahb(1'b1, REG_STATUS2, 32'h40);
    frm({OPC_PAGE_PROG, a, d}, 64, 1, 0, 0);
    rchk(REG_RESULT, 32'h0000_0203);
    rchk(REG_LAST_ADDR, {8'h0, a});
    ahb(1'b1, REG_RESULT, 32'h3);
    rchk(REG_RESULT, 32'h0000_0200);
    ahb(1'b1, REG_STATUS2, 32'h0);
    frm({8'h03, a, 32'h0}, 32, 0, 0, 0);
    frm({OPC_ERASE_4K, a, 32'h0}, 20, 0, 0, 0);
    frm({OPC_ERASE_4K, a, 32'h0}, 33, 0, 0, 0);
    ahb(1'b1, REG_STATUS3, 32'h4);
    frm({OPC_ERASE_4K, 24'h00_1000, 32'h0}, 32, 1, 0, 0);
    ahb(1'b1, REG_LOCK_LO, 32'hFFFF_FFFD);
    frm({OPC_ERASE_4K, 24'h00_1000, 32'h0}, 32, 0, 1, 0);
    frm({OPC_ERASE_4K, 24'h00_2000, 32'h0}, 32, 1, 0, 0);
    ahb(1'b1, REG_LOCK_HI, 32'h0000_3FFE);
    frm({OPC_ERASE_64K, 24'h01_0000, 32'h0}, 32, 0, 1, 0);
    give_verdict();
  end
endmodule

bind fbp_top fbp_top_properties u_fbp_top_properties (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_spi_cs_n(i_spi_cs_n),
  .o_erase_start(o_erase_start), .o_erase_op(o_erase_op), .o_prog_strobe(o_prog_strobe),
  .o_prog_op(o_prog_op), .o_op_refused(o_op_refused)
);

`default_nettype wire
